// *** design/quasi_bidir_port_logic.sv ***
`include "port_params.svh"
module quasi_bidir_port_logic (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core port access
  input wire port_pkg::core_req_s req_i,
  output logic [7:0] rdata_o,
  // External memory bus
  input wire logic external_access_select_i,
  input wire port_pkg::ext_bus_s bus_i,
  output logic [7:0] bus_rdata_o,
  // Alternate functions on port one
  input wire port_pkg::alt_out_s alt_i,
  output logic timer2_count_input_o,
  output logic timer2_aux_input_o,
  // Port zero pins
  input wire logic [7:0] port_zero_i,
  output logic [7:0] port_zero_o,
  output logic [7:0] port_zero_oe_o,
  // Port one to four pins, pull-down enables
  input wire logic [7:0] port_one_i,
  output logic [7:0] port_one_pd_o,
  input wire logic [7:0] port_two_i,
  output logic [7:0] port_two_pd_o,
  input wire logic [7:0] port_three_i,
  output logic [7:0] port_three_pd_o,
  input wire logic [3:0] port_four_i,
  output logic [3:0] port_four_pd_o
);
  import port_pkg::*;
  logic [3:0] state_reg;
  logic stage_en;
  logic sample_lo_en;
  logic sample_hi_en;
  logic bus_active;
  logic bus_read;
  logic [7:0] wr_sel;
  logic [7:0] lat0, lat1, lat2, lat3;
  logic [3:0] lat4;
  logic [7:0] stg0, stg1, stg2, stg3;
  logic [3:0] stg4;
  logic [7:0] smp0, smp1, smp2, smp3;
  logic [3:0] smp4;
  logic [7:0] rdata_next;
  logic [7:0] p1_drive;
  // Machine cycle state counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= 4'h0;
    end else if (state_reg == `STATE_LAST) begin
      state_reg <= 4'h0;
    end else begin
      state_reg <= state_reg + 4'h1;
    end
  end
  assign stage_en = (state_reg == 4'h0);
  assign sample_lo_en = (state_reg == `STATE_SAMPLE_LOW);
  assign sample_hi_en = (state_reg == `STATE_SAMPLE_HIGH);
  assign bus_active = !external_access_select_i && (bus_i.phase != BUS_IDLE);
  assign bus_read = bus_active && (bus_i.phase == BUS_READ);
  // Write strobe decode
  always_comb begin
    wr_sel = 8'h00;
    if (req_i.wr) begin
      wr_sel[req_i.sel] = 1'b1;
    end
  end
  // Port zero, latch forced to ones on bus use
  port_line_group #(.W(8)) u_zero (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_sel[`PORT_SEL_ZERO]),
    .wdata_i(req_i.wdata), .force_ones_i(bus_active), .stage_en_i(stage_en),
    .sample_en_i(sample_lo_en || bus_read), .pin_i(port_zero_i),
    .latch_o(lat0), .stage_o(stg0), .sample_o(smp0)
  );
  port_line_group #(.W(8)) u_one (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_sel[`PORT_SEL_ONE]),
    .wdata_i(req_i.wdata), .force_ones_i(1'b0), .stage_en_i(stage_en),
    .sample_en_i(sample_lo_en), .pin_i(port_one_i),
    .latch_o(lat1), .stage_o(stg1), .sample_o(smp1)
  );
  // Port two latch kept during bus use
  port_line_group #(.W(8)) u_two (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_sel[`PORT_SEL_TWO]),
    .wdata_i(req_i.wdata), .force_ones_i(1'b0), .stage_en_i(stage_en),
    .sample_en_i(sample_hi_en), .pin_i(port_two_i),
    .latch_o(lat2), .stage_o(stg2), .sample_o(smp2)
  );
  port_line_group #(.W(8)) u_three (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_sel[`PORT_SEL_THREE]),
    .wdata_i(req_i.wdata), .force_ones_i(1'b0), .stage_en_i(stage_en),
    .sample_en_i(sample_hi_en), .pin_i(port_three_i),
    .latch_o(lat3), .stage_o(stg3), .sample_o(smp3)
  );
  port_line_group #(.W(4)) u_four (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_sel[`PORT_SEL_FOUR]),
    .wdata_i(req_i.wdata[3:0]), .force_ones_i(1'b0), .stage_en_i(stage_en),
    .sample_en_i(sample_hi_en), .pin_i(port_four_i),
    .latch_o(lat4), .stage_o(stg4), .sample_o(smp4)
  );
  always_comb begin
    rdata_next = 8'hff;
    case (req_i.sel)
      `PORT_SEL_ZERO: rdata_next = req_i.rd_latch ? lat0 : smp0;
      `PORT_SEL_ONE: rdata_next = req_i.rd_latch ? lat1 : smp1;
      `PORT_SEL_TWO: rdata_next = req_i.rd_latch ? lat2 : smp2;
      `PORT_SEL_THREE: rdata_next = req_i.rd_latch ? lat3 : smp3;
      `PORT_SEL_FOUR: rdata_next = {`PORT_FOUR_FILL, req_i.rd_latch ? lat4 : smp4};
      default: rdata_next = 8'hff;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'hff;
    end else begin
      rdata_o <= rdata_next;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'hff;
    end else if (bus_read) begin
      bus_rdata_o <= smp0;
    end
  end
  assign p1_drive = {stg1[7:3] & alt_i.pulse, stg1[2:0]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_one_pd_o <= 8'h00;
      port_three_pd_o <= 8'h00;
      port_four_pd_o <= 4'h0;
    end else begin
      port_one_pd_o <= ~p1_drive;
      port_three_pd_o <= ~stg3;
      port_four_pd_o <= ~stg4;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_two_pd_o <= 8'h00;
    end else if (bus_active) begin
      port_two_pd_o <= ~bus_i.addr_hi;
    end else begin
      port_two_pd_o <= ~stg2;
    end
  end
  // Port zero open drain or bus drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_zero_o <= 8'h00;
      port_zero_oe_o <= 8'h00;
    end else if (bus_active) begin
      port_zero_o <= (bus_i.phase == BUS_ADDR) ? bus_i.addr_lo : bus_i.wdata;
      port_zero_oe_o <= bus_read ? 8'h00 : 8'hff;
    end else begin
      port_zero_o <= 8'h00;
      port_zero_oe_o <= ~stg0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer2_count_input_o <= 1'b1;
      timer2_aux_input_o <= 1'b1;
    end else begin
      timer2_count_input_o <= smp1[0];
      timer2_aux_input_o <= smp1[1];
    end
  end
endmodule

// *** shared/port_params.svh ***
`ifndef PORT_PARAMS_SVH
`define PORT_PARAMS_SVH
// Function
// - Thirty-six lines: four 8-bit ports and one 4-bit port, each independent.
// - A latch bit of 0 turns the pull-down on, driving the pin low.
// - A latch bit of 1 releases the pull-down; pull-up lines then go high.
// - Reset sets every latch bit so all lines are inputs.
// - A latch takes the internal bus value on its port write strobe.
// - Each port reads back either its latch or the sampled pin level.
// - Ports one to four are quasi-bidirectional with a weak pull-up.
// - Port zero is open drain; active pull-up only while it serves the bus.
// - Any external bus access through port zero (address, read or write) forces its latch to all ones.
// - Port zero drives low address/data, port two high address, on bus use.
// - On bus use port zero latch is forced to ones, port two latch kept.
// - Port one carries timer-2 inputs on bits 0,1 and pulse outputs on 3-7.
// - A written latch value is copied to the pin stage at the next state 0 and reaches the pin one clock later.
// - Pins sample at state 8 for ports zero/one, state 9 for ports two to four.
// - Read-modify-write reads the latch rather than the pin.
`define PORT_COUNT 5
`define PORT_WIDTH 8
`define PORT_FOUR_WIDTH 4
`define LATCH_RESET 8'hff
`define PORT_FOUR_FILL 4'hf
`define STATES_PER_CYCLE 4'hc
`define STATE_LAST 4'hb
`define STATE_SAMPLE_LOW 4'h8
`define STATE_SAMPLE_HIGH 4'h9
`define PORT_SEL_ZERO 3'h0
`define PORT_SEL_ONE 3'h1
`define PORT_SEL_TWO 3'h2
`define PORT_SEL_THREE 3'h3
`define PORT_SEL_FOUR 3'h4
`endif

// *** shared/port_pkg.sv ***
package port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] port_sel_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_READ = 2'b10,
    BUS_WRITE = 2'b11
  } bus_phase_e;
  typedef struct packed {
    logic wr;
    logic rd_latch;
    port_sel_t sel;
    byte_t wdata;
  } core_req_s;
  typedef struct packed {
    bus_phase_e phase;
    byte_t addr_lo;
    byte_t addr_hi;
    byte_t wdata;
  } ext_bus_s;
  typedef struct packed {
    logic [4:0] pulse;
  } alt_out_s;
endpackage

// *** design/port_line_group.sv ***
`include "port_params.svh"
module port_line_group #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic force_ones_i,
  input wire logic stage_en_i,
  input wire logic sample_en_i,
  // Pin side
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] latch_o,
  output logic [W-1:0] stage_o,
  output logic [W-1:0] sample_o
);
  logic [W-1:0] latch_reg;
  logic [W-1:0] stage_reg;
  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] sample_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= '1;
    end else if (force_ones_i) begin
      latch_reg <= '1;
    end else if (wr_i) begin
      latch_reg <= wdata_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= '1;
    end else if (stage_en_i) begin
      stage_reg <= latch_reg;
    end
  end
  // Pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= '1;
    end else if (sample_en_i) begin
      sample_reg <= sync2_reg;
    end
  end
  assign latch_o = latch_reg;
  assign stage_o = stage_reg;
  assign sample_o = sample_reg;
endmodule

// *** test/port_checker.sv ***
module port_checker
  import port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire port_pkg::core_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic external_access_select_i,
  input wire port_pkg::ext_bus_s bus_i,
  input wire logic [7:0] port_zero_o,
  input wire logic [7:0] port_zero_oe_o,
  input wire logic [7:0] port_two_pd_o,
  input wire logic [7:0] port_three_pd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic on_bus;
  assign on_bus = !external_access_select_i && bus_i.phase != BUS_IDLE;
  sequence addr_held;
    (on_bus && bus_i.phase == BUS_ADDR && $stable(bus_i.addr_lo))[*2];
  endsequence
  sequence hi_held;
    (on_bus && $stable(bus_i.addr_hi))[*2];
  endsequence
  a_reset_inputs: assert property (
    $fell(rst_i) |-> (port_zero_oe_o | port_two_pd_o | port_three_pd_o) == 8'h00) else $error("reset state");
  a_four_upper_fixed: assert property (
    req_i.rd_latch && req_i.sel == 3'h4 |=> rdata_o[7:4] == 4'hf) else $error("upper nibble");
  a_unused_sel_ones: assert property (
    req_i.sel > 3'h4 |=> rdata_o == 8'hff) else $error("unused select");
  a_zero_open_drain: assert property (
    (!on_bus)[*3] |-> (port_zero_o & port_zero_oe_o) == 8'h00) else $error("open drain");
  a_addr_low_drive: assert property (
    addr_held |-> port_zero_oe_o == 8'hff && port_zero_o == bus_i.addr_lo) else $error("low address");
  a_addr_high_drive: assert property (
    hi_held |-> port_two_pd_o == ~bus_i.addr_hi) else $error("high address");
  a_read_release: assert property (
    (on_bus && bus_i.phase == BUS_READ)[*2] |-> port_zero_oe_o == 8'h00) else $error("read release");
  a_stage_period: assert property (
    $changed(port_three_pd_o) |=> $stable(port_three_pd_o)[*8]) else $error("stage period");
endmodule
bind quasi_bidir_port_logic port_checker port_checker_inst (.clk_i, .rst_i, .req_i, .rdata_o,
  .external_access_select_i, .bus_i, .port_zero_o, .port_zero_oe_o, .port_two_pd_o, .port_three_pd_o);

// *** test/pin_loads.sv ***
module pin_loads (
  // Design drive
  input wire logic [7:0] zero_val_i,
  input wire logic [7:0] zero_oe_i,
  input wire logic [27:0] pd_i,
  // Outside loads
  input wire logic [7:0] zero_ext_i,
  input wire logic [27:0] ext_low_i,
  // Pin levels
  output logic [7:0] zero_pin_o,
  output logic [27:0] pin_o
);
  assign zero_pin_o = (zero_oe_i & zero_val_i) | (~zero_oe_i & zero_ext_i);
  assign pin_o = ~(pd_i | ext_low_i);
endmodule

// *** test/quasi_bidir_port_logic_tb_top.sv ***
module quasi_bidir_port_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import port_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  core_req_s req_i = '0;
  logic ext_sel = 1;
  ext_bus_s bus_i = '0;
  alt_out_s alt_i = '{pulse: 5'h1f};
  logic [7:0] zero_ext = 8'hff;
  logic [27:0] ext_low = '0;
  logic [7:0] rdata, bus_rdata, zero_o, zero_oe, zero_pin;
  logic [27:0] pd, pin;
  logic [31:0] drv;
  logic t2c, t2a;
  int fail_count = 0;
  int checks = 0;
  assign drv = {pd[23:0], zero_oe};
  always #5 clk_i = ~clk_i;
  quasi_bidir_port_logic quasi_bidir_port_logic_inst (.clk_i, .rst_i, .req_i, .rdata_o(rdata),
    .external_access_select_i(ext_sel), .bus_i, .bus_rdata_o(bus_rdata), .alt_i,
    .timer2_count_input_o(t2c), .timer2_aux_input_o(t2a), .port_zero_i(zero_pin), .port_zero_o(zero_o),
    .port_zero_oe_o(zero_oe), .port_one_i(pin[7:0]), .port_one_pd_o(pd[7:0]), .port_two_i(pin[15:8]),
    .port_two_pd_o(pd[15:8]), .port_three_i(pin[23:16]), .port_three_pd_o(pd[23:16]),
    .port_four_i(pin[27:24]), .port_four_pd_o(pd[27:24]));
  pin_loads pin_loads_inst (.zero_val_i(zero_o), .zero_oe_i(zero_oe), .pd_i(pd), .zero_ext_i(zero_ext),
    .ext_low_i(ext_low), .zero_pin_o(zero_pin), .pin_o(pin));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input port_sel_t s, input byte_t d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b1, rd_latch: 1'b0, sel: s, wdata: d};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask
  task automatic rd(input port_sel_t s, input logic lat, input byte_t exp);
    @(posedge clk_i);
    req_i <= '{wr: 1'b0, rd_latch: lat, sel: s, wdata: 8'h00};
    tick(1);
    cmp(rdata, exp);
  endtask
  task automatic check_reset();
    for (int s = 0; s < 6; s++) rd(port_sel_t'(s), 1'b1, 8'hff);
    cmp(drv[31:24] | drv[23:16] | drv[15:8] | drv[7:0], 8'h00);
  endtask
  task automatic check_levels();
    for (int s = 0; s < 4; s++) begin
      wr(port_sel_t'(s), 8'h5a ^ 8'(s));
      rd(port_sel_t'(s), 1'b1, 8'h5a ^ 8'(s));
      tick(30);
      cmp(drv[8*s +: 8], ~(8'h5a ^ 8'(s)));
      rd(port_sel_t'(s), 1'b0, 8'h5a ^ 8'(s));
    end
    wr(3'h4, 8'h50);
    rd(3'h4, 1'b1, 8'hf0);
    tick(30);
    cmp({4'h0, pd[27:24]}, 8'h0f);
    rd(3'h4, 1'b0, 8'hf0);
  endtask
  task automatic check_alt();
    @(posedge clk_i);
    ext_low <= 28'h0010001;
    tick(30);
    rd(3'h3, 1'b0, 8'h58);
    cmp({6'h00, t2a, t2c}, 8'h02);
    @(posedge clk_i);
    alt_i <= '{pulse: 5'h00};
    tick(30);
    cmp(pd[7:0], 8'hfc);
  endtask
  task automatic check_bus();
    @(posedge clk_i);
    ext_sel <= 1'b0;
    bus_i <= '{phase: BUS_ADDR, addr_lo: 8'h12, addr_hi: 8'h34, wdata: 8'h56};
    tick(3);
    cmp(zero_o & zero_oe, 8'h12);
    cmp(pd[15:8], 8'hcb);
    @(posedge clk_i);
    bus_i.phase <= BUS_WRITE;
    tick(3);
    cmp(zero_o & zero_oe, 8'h56);
    @(posedge clk_i);
    bus_i.phase <= BUS_READ;
    zero_ext <= 8'h77;
    tick(6);
    cmp(zero_oe, 8'h00);
    cmp(bus_rdata, 8'h77);
    @(posedge clk_i);
    ext_sel <= 1'b1;
    bus_i.phase <= BUS_IDLE;
    zero_ext <= 8'hff;
    rd(3'h0, 1'b1, 8'hff);
    rd(3'h2, 1'b1, 8'h58);
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    check_reset();
    check_levels();
    check_alt();
    check_bus();
    complete_run();
  end
endmodule
